// [cfg_cmd_interp.sv]
`timescale 1ns/1ns
// Operation
// R01: read frame is header, length two, escape, then register number.
// R02: valid read answers acknowledge byte, register number, then register contents.
// R03: read contents go out as raw byte, never escape encoded.
// R04: read of unknown register answers single negative acknowledge byte.
// R05: working transmit and receive channels live in volatile registers.
// R06: power-up channels come from the non-volatile channel registers.
// R07: channels 0-1 valid in hopping mode, 0-5 in low-power mode.
// R08: host should program equal transmit and receive channels for carrier sense.
// R09: volatile power select sets mode and power; non-volatile twin gives power-up value.
// R10: power select codes map to mode and one of four power levels.
// R11: low-power and hopping modules never talk; all hopping settings interoperate.
// R12: baud rate from volatile register; power-up from non-volatile, default 2400.
// R13: baud code maps to eight fixed rates.
// R14: host must run the same baud rate as the module.
// R15: host should stay at or below 9600 baud in low-power mode.
// R16: role register: zero is subordinate, one is normal, normal by default.
// R17: subordinate modules talk only to normal-role modules.
// R18: write frame is header, length, register, value; large values escaped.
// R19: at power-up all non-volatile registers are copied to volatile twins.
// R20: volatile writes act at once, non-volatile writes take about 16 ms.
// R21: new baud rate applies only after the write frame is fully received.
// R22: malformed frames are discarded and parsing resyncs on the next header.
module cfg_cmd_interp
  import cfg_pkg::*;
#(
  parameter int CLK_HZ_P = CLK_HZ,
  parameter int NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial configuration port
  input wire logic serial_rx,
  output logic serial_tx,
  // working configuration and non-volatile write status
  output logic [7:0] tx_channel,
  output logic [7:0] rx_channel,
  output logic hopping_mode,
  output logic [1:0] power_level,
  output logic subordinate_role,
  output logic nv_write_busy,
  // peer admission
  input wire logic peer_hopping,
  input wire logic peer_subordinate,
  output logic peer_accept
);
  localparam int CNT_W = $clog2(NV_WRITE_CYCLES_P + 1);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_LEN = 3'h1,
    S_ADDR = 3'h3,
    S_VAL = 3'h2,
    S_RDREG = 3'h6,
    S_ADDR3 = 3'h7,
    S_ESC3 = 3'h5,
    S_VAL3 = 3'h4
  } parse_state_t;

  typedef struct packed {
    parse_state_t st;
    logic [7:0] addr;
    logic copy_pend;
    logic [NUM_CFG-1:0][7:0] nv;
    logic [NUM_CFG-1:0][7:0] vol;
    logic nv_busy;
    logic [2:0] nv_idx;
    logic [7:0] nv_val;
    logic [CNT_W-1:0] nv_cnt;
    logic [2:0][7:0] reply;
    logic [1:0] reply_len;
    logic [1:0] reply_pos;
  } ctl_state_t;

  localparam logic [NUM_CFG-1:0][7:0] CFG_DEFAULTS = {DEF_ROLE, DEF_BAUD, DEF_PWR, DEF_CH, DEF_CH};
  localparam ctl_state_t CTL_RESET = '{
    st: S_IDLE,
    copy_pend: 1'b1,
    nv: CFG_DEFAULTS,
    vol: CFG_DEFAULTS,
    default: '0
  };

  function automatic logic [DIV_W-1:0] baud_div(input logic [7:0] code);
    baud_div = DIV_W'(CLK_HZ_P / baud_rate(code[2:0]));
  endfunction

  byte_link_if l ();

  uart_core u_uart (
    .clk(clk),
    .rst_b(rst_b),
    .serial_rx(serial_rx),
    .serial_tx(serial_tx),
    .l(l)
  );

  ctl_state_t q;
  ctl_state_t n;
  logic do_read;
  logic [7:0] rd_addr;
  logic [7:0] rd_value;
  logic do_write;
  logic [7:0] wr_addr;
  logic [7:0] wr_val;
  logic [2:0] wr_idx;
  logic wr_ok;
  logic [7:0] rx_byte;

  always_comb begin
    n = q;
    do_read = 1'b0;
    do_write = 1'b0;
    rd_addr = '0;
    wr_addr = q.addr;
    wr_val = '0;
    rx_byte = l.rx_data;
    // the copy step takes one cycle, far shorter than any character time
    if (q.copy_pend) begin
      n.vol = q.nv; // R19 R06
      n.copy_pend = 1'b0;
    end else if (l.rx_valid) begin
      if (rx_byte == HDR_BYTE) begin
        // 0xff never occurs inside a well-formed frame, so it always restarts
        n.st = S_LEN; // R22
      end else begin
        case (q.st)
          S_LEN: begin
            if (rx_byte == LEN_SHORT) begin
              n.st = S_ADDR; // R01 R18
            end else if (rx_byte == LEN_LONG) begin
              n.st = S_ADDR3; // R18
            end else begin
              n.st = S_IDLE; // R22
            end
          end
          S_ADDR: begin
            if (rx_byte == ESC_BYTE) begin
              n.st = S_RDREG; // R01
            end else if (rx_byte[7]) begin
              n.st = S_IDLE; // R22
            end else begin
              n.addr = rx_byte;
              n.st = S_VAL;
            end
          end
          S_VAL: begin
            n.st = S_IDLE;
            if (!rx_byte[7]) begin
              do_write = 1'b1; // R18
              wr_val = rx_byte;
            end
          end
          S_RDREG: begin
            n.st = S_IDLE;
            do_read = 1'b1; // R01
            rd_addr = rx_byte;
          end
          S_ADDR3: begin
            if (rx_byte[7]) begin
              n.st = S_IDLE; // R22
            end else begin
              n.addr = rx_byte;
              n.st = S_ESC3;
            end
          end
          S_ESC3: begin
            n.st = (rx_byte == ESC_BYTE) ? S_VAL3 : S_IDLE; // R18 R22
          end
          S_VAL3: begin
            n.st = S_IDLE;
            if (!rx_byte[7]) begin
              do_write = 1'b1; // R18
              wr_val = VALUE_TOP | rx_byte;
            end
          end
          default: n.st = S_IDLE;
        endcase
      end
    end

    rd_value = is_nv(rd_addr) ? q.nv[cfg_idx(rd_addr)] : q.vol[cfg_idx(rd_addr)];
    // a read that lands while a reply is still going out is dropped
    if (do_read && q.reply_len == 2'h0) begin
      n.reply_pos = 2'h0;
      if (reg_known(rd_addr)) begin
        n.reply = {rd_value, rd_addr, ACK_BYTE}; // R02 R03
        n.reply_len = 2'h3;
      end else begin
        n.reply = {8'h00, 8'h00, NACK_BYTE}; // R04
        n.reply_len = 2'h1;
      end
    end else if (l.tx_valid && l.tx_ready) begin
      if (2'(q.reply_pos + 2'h1) == q.reply_len) begin
        n.reply_len = 2'h0;
        n.reply_pos = 2'h0;
      end else begin
        n.reply_pos = 2'(q.reply_pos + 2'h1);
      end
    end

    if (q.nv_busy) begin
      if (q.nv_cnt == '0) begin
        n.nv[q.nv_idx] = q.nv_val; // R20
        n.nv_busy = 1'b0;
      end else begin
        n.nv_cnt = q.nv_cnt - 1'b1; // R20
      end
    end

    wr_idx = cfg_idx(wr_addr);
    wr_ok = value_ok(wr_idx, wr_val, is_hopping(is_nv(wr_addr) ? q.nv[IDX_PWR] : q.vol[IDX_PWR])); // R07
    if (do_write && reg_known(wr_addr) && wr_ok) begin
      if (!is_nv(wr_addr)) begin
        // volatile copy governs the block; takes effect on the next edge
        n.vol[wr_idx] = wr_val; // R05 R09 R12 R16 R20 R21
      end else if (!q.nv_busy) begin
        n.nv_busy = 1'b1; // R20
        n.nv_idx = wr_idx;
        n.nv_val = wr_val;
        n.nv_cnt = CNT_W'(NV_WRITE_CYCLES_P - 1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= CTL_RESET;
    end else begin
      q <= n;
    end
  end

  // the uart latches the divisor per character, so the switch follows the frame
  assign l.baud_div = baud_div(q.vol[IDX_BAUD]); // R12 R13 R21
  assign l.tx_valid = (q.reply_len != 2'h0);
  assign l.tx_data = q.reply[q.reply_pos];

  assign tx_channel = q.vol[IDX_TX]; // R05
  assign rx_channel = q.vol[IDX_RX]; // R05
  assign hopping_mode = is_hopping(q.vol[IDX_PWR]); // R09 R10
  assign power_level = q.vol[IDX_PWR][1:0]; // R10
  assign subordinate_role = (q.vol[IDX_ROLE] == ROLE_SUB); // R16
  assign nv_write_busy = q.nv_busy;
  // mode must match, and two subordinates never pair
  assign peer_accept = (peer_hopping == hopping_mode) && !(subordinate_role && peer_subordinate); // R11 R17

  ack_reply_a: assert property (@(posedge clk) disable iff (!rst_b) // R02
    do_read && q.reply_len == 2'h0 && reg_known(rd_addr) |=>
      q.reply_len == 2'h3 && q.reply[0] == ACK_BYTE && q.reply[1] == $past(rd_addr)) else $error("read ack wrong");

  raw_value_a: assert property (@(posedge clk) disable iff (!rst_b) // R03
    do_read && q.reply_len == 2'h0 && reg_known(rd_addr) |=> q.reply[2] == $past(rd_value)) else $error("read value altered");

  nack_reply_a: assert property (@(posedge clk) disable iff (!rst_b) // R04
    do_read && q.reply_len == 2'h0 && !reg_known(rd_addr) |=>
      q.reply_len == 2'h1 && l.tx_data == NACK_BYTE) else $error("nack missing");

  copy_reset_a: assert property (@(posedge clk) disable iff (!rst_b) // R19
    $rose(rst_b) |=> q.vol == q.nv && !q.copy_pend) else $error("power-up copy missing");

  nv_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
    q.nv_busy && q.nv_cnt != '0 |=> $stable(q.nv) && q.nv_busy) else $error("nv write finished early");

  nv_commit_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
    q.nv_busy && q.nv_cnt == '0 |=> !q.nv_busy && q.nv[$past(q.nv_idx)] == $past(q.nv_val)) else $error("nv commit lost");

  chan_reject_a: assert property (@(posedge clk) disable iff (!rst_b) // R07
    do_write && wr_addr == V_TX_CH && wr_val >= (hopping_mode ? HOP_CHANNELS : LP_CHANNELS) |=>
      $stable(tx_channel)) else $error("bad channel accepted");

  hop_decode_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
    do_write && wr_addr == V_PWR && wr_val <= PWR_MAX |=>
      hopping_mode == ($past(wr_val) >= PWR_HOP_LO && $past(wr_val) <= PWR_HOP_HI) &&
      power_level == $past(wr_val[1:0])) else $error("power decode wrong");

  role_decode_a: assert property (@(posedge clk) disable iff (!rst_b) // R16
    do_write && wr_addr == V_ROLE && wr_val <= ROLE_NORMAL |=>
      subordinate_role == ($past(wr_val) == ROLE_SUB)) else $error("role decode wrong");

  resync_hdr_a: assert property (@(posedge clk) disable iff (!rst_b) // R22
    !q.copy_pend && l.rx_valid && l.rx_data == HDR_BYTE |=> q.st == S_LEN) else $error("no resync on header");

  peer_filter_a: assert property (@(posedge clk) disable iff (!rst_b) // R17
    subordinate_role && peer_subordinate |-> !peer_accept) else $error("subordinate pair accepted");

  read_escape_a: assert property (@(posedge clk) disable iff (!rst_b) // R01
    !q.copy_pend && l.rx_valid && q.st == S_ADDR && l.rx_data == ESC_BYTE |=>
      q.st == S_RDREG) else $error("read escape missed");

  vol_apply_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
    do_write && reg_known(wr_addr) && !is_nv(wr_addr) && wr_ok |=>
      q.vol[$past(wr_idx)] == $past(wr_val)) else $error("volatile write lost");

  nv_start_a: assert property (@(posedge clk) disable iff (!rst_b) // R20
    do_write && reg_known(wr_addr) && is_nv(wr_addr) && wr_ok && !q.nv_busy |=>
      nv_write_busy && q.nv_cnt == CNT_W'(NV_WRITE_CYCLES_P - 1)) else $error("nv write not started");

  nack_single_a: assert property (@(posedge clk) disable iff (!rst_b) // R04
    q.reply_len == 2'h1 && l.tx_valid && l.tx_ready |=> q.reply_len == 2'h0) else $error("nack not single");
endmodule

// [cfg_pkg.sv]
package cfg_pkg;
  // framing bytes of the serial configuration protocol
  localparam logic [7:0] HDR_BYTE = 8'hff;
  localparam logic [7:0] LEN_SHORT = 8'h02;
  localparam logic [7:0] LEN_LONG = 8'h03;
  localparam logic [7:0] ESC_BYTE = 8'hfe;
  localparam logic [7:0] ACK_BYTE = 8'h06;
  localparam logic [7:0] NACK_BYTE = 8'h15;
  localparam logic [7:0] VALUE_TOP = 8'h80;

  // register numbers, non-volatile then volatile
  localparam logic [7:0] NV_TX_CH = 8'h00;
  localparam logic [7:0] NV_RX_CH = 8'h01;
  localparam logic [7:0] NV_PWR = 8'h02;
  localparam logic [7:0] NV_BAUD = 8'h03;
  localparam logic [7:0] NV_ROLE = 8'h04;
  localparam logic [7:0] V_TX_CH = 8'h4b;
  localparam logic [7:0] V_RX_CH = 8'h4c;
  localparam logic [7:0] V_PWR = 8'h4d;
  localparam logic [7:0] V_BAUD = 8'h4e;
  localparam logic [7:0] V_ROLE = 8'h4f;
  localparam int NUM_CFG = 5;
  localparam logic [2:0] IDX_TX = 3'h0;
  localparam logic [2:0] IDX_RX = 3'h1;
  localparam logic [2:0] IDX_PWR = 3'h2;
  localparam logic [2:0] IDX_BAUD = 3'h3;
  localparam logic [2:0] IDX_ROLE = 3'h4;

  // factory defaults of the non-volatile set
  localparam logic [7:0] DEF_CH = 8'h00;
  localparam logic [7:0] DEF_PWR = 8'h03;
  localparam logic [7:0] DEF_BAUD = 8'h00;
  localparam logic [7:0] DEF_ROLE = 8'h01;

  // value limits
  localparam logic [7:0] HOP_CHANNELS = 8'h02;
  localparam logic [7:0] LP_CHANNELS = 8'h06;
  localparam logic [7:0] PWR_MAX = 8'h07;
  localparam logic [7:0] PWR_HOP_LO = 8'h01;
  localparam logic [7:0] PWR_HOP_HI = 8'h04;
  localparam logic [7:0] BAUD_MAX = 8'h07;
  localparam logic [7:0] ROLE_SUB = 8'h00;
  localparam logic [7:0] ROLE_NORMAL = 8'h01;

  // timing
  localparam int CLK_HZ = 125000000;
  localparam int NV_WRITE_MS = 16;
  localparam int NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_MS;
  localparam int DIV_W = 20;
  localparam logic [3:0] STOP_BIT = 4'h9;

  function automatic int baud_rate(input logic [2:0] code);
    case (code)
      3'h0: baud_rate = 2400;
      3'h1: baud_rate = 9600;
      3'h2: baud_rate = 19200;
      3'h3: baud_rate = 38400;
      3'h4: baud_rate = 57600;
      3'h5: baud_rate = 115200;
      3'h6: baud_rate = 10400;
      default: baud_rate = 31250;
    endcase
  endfunction

  function automatic logic is_hopping(input logic [7:0] pwr);
    is_hopping = (pwr >= PWR_HOP_LO) && (pwr <= PWR_HOP_HI);
  endfunction

  function automatic logic is_nv(input logic [7:0] a);
    is_nv = (a <= NV_ROLE);
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a <= NV_ROLE) || ((a >= V_TX_CH) && (a <= V_ROLE));
  endfunction

  function automatic logic [2:0] cfg_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - V_TX_CH;
    cfg_idx = is_nv(a) ? a[2:0] : d[2:0];
  endfunction

  function automatic logic value_ok(input logic [2:0] idx, input logic [7:0] v, input logic hop);
    case (idx)
      IDX_TX, IDX_RX: value_ok = v < (hop ? HOP_CHANNELS : LP_CHANNELS);
      IDX_PWR: value_ok = v <= PWR_MAX;
      IDX_BAUD: value_ok = v <= BAUD_MAX;
      default: value_ok = v <= ROLE_NORMAL;
    endcase
  endfunction
endpackage

// [byte_link_if.sv]
`timescale 1ns/1ns
interface byte_link_if;
  import cfg_pkg::*;
  logic [7:0] rx_data;
  logic rx_valid;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [DIV_W-1:0] baud_div;
  modport core (input tx_data, input tx_valid, input baud_div, output rx_data, output rx_valid, output tx_ready);
  modport ctrl (output tx_data, output tx_valid, output baud_div, input rx_data, input rx_valid, input tx_ready);
endinterface

// [uart_core.sv]
`timescale 1ns/1ns
module uart_core
  import cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // serial pins
  input wire logic serial_rx,
  output logic serial_tx,
  // byte side
  byte_link_if.core l
);
  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic rx_busy;
    logic [DIV_W-1:0] rx_cnt;
    logic [DIV_W-1:0] rx_div;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_valid;
    logic tx_busy;
    logic [DIV_W-1:0] tx_cnt;
    logic [DIV_W-1:0] tx_div;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;
    logic tx_line;
  } uart_state_t;

  localparam uart_state_t UART_RESET = '{rx_meta: 1'b1, rx_sync: 1'b1, tx_line: 1'b1, default: '0};

  uart_state_t q;
  uart_state_t n;

  always_comb begin
    n = q;
    n.rx_valid = 1'b0;
    n.rx_meta = serial_rx;
    n.rx_sync = q.rx_meta;
    // the divisor is latched per character so a rate change never splits a byte
    if (!q.rx_busy) begin
      if (!q.rx_sync) begin
        n.rx_busy = 1'b1;
        n.rx_div = l.baud_div;
        n.rx_cnt = {1'b0, l.baud_div[DIV_W-1:1]};
        n.rx_bit = 4'h0;
      end
    end else if (q.rx_cnt != '0) begin
      n.rx_cnt = q.rx_cnt - 1'b1;
    end else begin
      n.rx_cnt = q.rx_div - 1'b1;
      n.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0) begin
        // a glitch shorter than half a bit is not a start bit
        if (q.rx_sync) begin
          n.rx_busy = 1'b0;
        end
      end else if (q.rx_bit == STOP_BIT) begin
        n.rx_busy = 1'b0;
        if (q.rx_sync) begin
          n.rx_valid = 1'b1;
          n.rx_data = q.rx_shift;
        end
      end else begin
        n.rx_shift = {q.rx_sync, q.rx_shift[7:1]};
      end
    end
    if (!q.tx_busy) begin
      if (l.tx_valid) begin
        n.tx_busy = 1'b1;
        n.tx_div = l.baud_div;
        n.tx_cnt = l.baud_div - 1'b1;
        n.tx_bit = 4'h0;
        n.tx_shift = {1'b1, l.tx_data, 1'b0};
        n.tx_line = 1'b0;
      end
    end else if (q.tx_cnt != '0) begin
      n.tx_cnt = q.tx_cnt - 1'b1;
    end else if (q.tx_bit == STOP_BIT) begin
      n.tx_busy = 1'b0;
      n.tx_line = 1'b1;
    end else begin
      n.tx_cnt = q.tx_div - 1'b1;
      n.tx_bit = q.tx_bit + 4'h1;
      n.tx_shift = {1'b1, q.tx_shift[9:1]};
      n.tx_line = q.tx_shift[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= UART_RESET;
    end else begin
      q <= n;
    end
  end

  assign serial_tx = q.tx_line;
  assign l.rx_data = q.rx_data;
  assign l.rx_valid = q.rx_valid;
  assign l.tx_ready = !q.tx_busy;

  baud_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R21
    q.tx_busy && $past(q.tx_busy) |-> $stable(q.tx_div)) else $error("tx divisor changed mid character");
endmodule

// [host_model.sv]
`timescale 1ns/1ns
module host_model (
  // clock
  input wire logic clk,
  // serial pins, seen from the host
  output logic serial_rx,
  input wire logic serial_tx
);
  // the module's receive line idles high between characters
  initial serial_rx = 1'b1;

  // one 8N1 character, lsb first, at the bit time the module uses
  task automatic send_byte(input logic [7:0] b, input int d);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx = f[i];
      repeat (d) @(posedge clk);
      #1;
    end
  endtask

  // read is ff 02 fe reg, short write is ff 02 reg value
  task automatic send4(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] e,
                       input int d);
    send_byte(a, d);
    send_byte(b, d);
    send_byte(c, d);
    send_byte(e, d);
  endtask

  // ok stays low when no start bit shows within lim cycles or framing is broken
  task automatic recv_byte(output logic [7:0] b, output bit ok, input int d, input int lim);
    int n;
    ok = 1'b0;
    b = 8'h00;
    n = 0;
    // every look is 1 ns after the edge, so a bit launched on that edge has settled
    while (serial_tx !== 1'b0 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (serial_tx !== 1'b0) begin
      return;
    end
    repeat (d / 2) @(posedge clk);
    #1;
    ok = (serial_tx === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (d) @(posedge clk);
      #1;
      b[i] = serial_tx;
    end
    repeat (d) @(posedge clk);
    #1;
    ok = ok && (serial_tx === 1'b1);
  endtask
endmodule

// [cfg_cmd_interp_tb.sv]
`timescale 1ns/1ns
module cfg_cmd_interp_tb;
  import cfg_pkg::*;
  // small clock figure keeps 2400 baud at 480 cycles a bit
  localparam int CLK_HZ_T = 1152000;
  localparam int NV_CYC_T = 20;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic serial_rx;
  logic serial_tx;
  logic [7:0] tx_channel;
  logic [7:0] rx_channel;
  logic hopping_mode;
  logic [1:0] power_level;
  logic subordinate_role;
  logic nv_write_busy;
  logic peer_hopping = 1'b1;
  logic peer_subordinate = 1'b0;
  logic peer_accept;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nv_hi = 0;
  int bit_d = CLK_HZ_T / 2400;

  cfg_cmd_interp #(.CLK_HZ_P(CLK_HZ_T), .NV_WRITE_CYCLES_P(NV_CYC_T)) u_cfg_cmd_interp (
    .clk(clk), .rst_b(rst_b), .serial_rx(serial_rx), .serial_tx(serial_tx),
    .tx_channel(tx_channel), .rx_channel(rx_channel), .hopping_mode(hopping_mode),
    .power_level(power_level), .subordinate_role(subordinate_role), .nv_write_busy(nv_write_busy),
    .peer_hopping(peer_hopping), .peer_subordinate(peer_subordinate), .peer_accept(peer_accept));

  host_model u_host_model (.clk(clk), .serial_rx(serial_rx), .serial_tx(serial_tx));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // counts edges at which a non-volatile write is seen pending
  always @(posedge clk) begin
    if (nv_write_busy === 1'b1) begin
      nv_hi <= nv_hi + 1;
    end
  end

  // the hang guard covers the slow frame at 2400, the low-power tail at 9600 and the rest
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      summarize();
    end
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    u_host_model.send4(HDR_BYTE, LEN_SHORT, r, v, bit_d);
    step();
    step();
  endtask

  // at 9600 the reply starts inside the host's stop bit, so listening runs beside sending
  task automatic rd(input logic [7:0] r, input logic [7:0] v, input bit known);
    logic [7:0] b0, b1, b2;
    bit k0, k1, k2;
    fork
      u_host_model.send4(HDR_BYTE, LEN_SHORT, ESC_BYTE, r, bit_d);
      begin
        u_host_model.recv_byte(b0, k0, bit_d, 50 * bit_d);
        u_host_model.recv_byte(b1, k1, bit_d, 3 * bit_d);
        if (known) begin
          u_host_model.recv_byte(b2, k2, bit_d, 3 * bit_d);
        end
      end
    join
    check({7'h00, k0}, 8'h01, "reply framing");
    if (known) begin
      check({6'h00, k1, k2}, 8'h03, "reply framing later bytes");
      check(b0, ACK_BYTE, "ack byte");
      check(b1, r, "echoed register");
      check(b2, v, "register value");
    end else begin
      check(b0, NACK_BYTE, "nack byte");
      check({7'h00, k1}, 8'h00, "nothing after nack");
    end
    repeat (bit_d) @(posedge clk);
    #1;
  endtask

  task automatic t_reset_state;
    step();
    check(tx_channel, DEF_CH, "tx channel at start");
    check(rx_channel, DEF_CH, "rx channel at start");
    check({7'h00, hopping_mode}, 8'h01, "hopping at start");
    check({6'h00, power_level}, 8'h03, "power at start");
    check({7'h00, subordinate_role}, 8'h00, "role at start");
    check({7'h00, nv_write_busy}, 8'h00, "nv idle at start");
  endtask

  task automatic t_baud_switch;
    wr(V_BAUD, 8'h05);
    bit_d = CLK_HZ_T / 115200;
    rd(V_BAUD, 8'h05, 1'b1);
    rd(NV_BAUD, DEF_BAUD, 1'b1);
  endtask

  task automatic t_read_regs;
    wr(V_TX_CH, 8'h01);
    wr(V_RX_CH, 8'h01);
    rd(V_TX_CH, 8'h01, 1'b1);
    check(rx_channel, 8'h01, "rx channel written");
    rd(8'h10, 8'h00, 1'b0);
    rd(V_ROLE, ROLE_NORMAL, 1'b1);
    rd(NV_ROLE, DEF_ROLE, 1'b1);
  endtask

  task automatic t_channel_range;
    wr(V_TX_CH, 8'h02);
    check(tx_channel, 8'h01, "channel 2 refused in hopping");
    wr(V_PWR, 8'h00);
    wr(V_TX_CH, 8'h05);
    check(tx_channel, 8'h05, "channel 5 in low power");
    wr(V_TX_CH, 8'h06);
    check(tx_channel, 8'h05, "channel 6 refused");
    // escaped form carries 0x81; dropping the top bit would wrongly store channel 1
    u_host_model.send4(HDR_BYTE, LEN_LONG, V_TX_CH, ESC_BYTE, bit_d);
    u_host_model.send_byte(8'h01, bit_d);
    step();
    step();
    check(tx_channel, 8'h05, "escaped value 0x81 refused");
  endtask

  task automatic t_power_codes;
    logic hop;
    for (int v = 0; v < 8; v++) begin
      hop = (v >= 1 && v <= 4);
      wr(v[7:0], 8'h00);
      wr(V_PWR, v[7:0]);
      check({7'h00, hopping_mode}, {7'h00, hop}, "mode decode");
      check({6'h00, power_level}, {6'h00, v[1:0]}, "power decode");
      peer_hopping = 1'b1;
      step();
      check({7'h00, peer_accept}, {7'h00, hop}, "hopping peer");
      peer_hopping = 1'b0;
      step();
      check({7'h00, peer_accept}, {7'h00, ~hop}, "low power peer");
    end
  endtask

  task automatic t_role;
    wr(V_BAUD, 8'h01);
    // low-power mode from here on, so the host drops to 9600 for link quality
    bit_d = CLK_HZ_T / 9600;
    wr(V_ROLE, ROLE_SUB);
    check({7'h00, subordinate_role}, 8'h01, "subordinate set");
    peer_subordinate = 1'b1;
    step();
    check({7'h00, peer_accept}, 8'h00, "two subordinates");
    wr(V_ROLE, 8'h02);
    check({7'h00, subordinate_role}, 8'h01, "role 2 refused");
    peer_subordinate = 1'b0;
    step();
    check({7'h00, peer_accept}, 8'h01, "subordinate to normal");
    wr(V_ROLE, ROLE_NORMAL);
    peer_subordinate = 1'b1;
    step();
    check({7'h00, peer_accept}, 8'h01, "normal to subordinate");
  endtask

  task automatic t_nv_write;
    int n0;
    n0 = nv_hi;
    wr(NV_TX_CH, 8'h01);
    repeat (NV_CYC_T) step();
    check({7'h00, nv_write_busy}, 8'h00, "nv write done");
    check(8'(nv_hi - n0), 8'(NV_CYC_T), "nv write length");
    check(tx_channel, 8'h05, "volatile channel kept");
    rd(NV_TX_CH, 8'h01, 1'b1);
  endtask

  task automatic t_resync;
    u_host_model.send_byte(HDR_BYTE, bit_d);
    u_host_model.send_byte(LEN_SHORT, bit_d);
    rd(V_TX_CH, 8'h05, 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    step();
    t_reset_state();
    t_baud_switch();
    t_read_regs();
    t_channel_range();
    t_power_codes();
    t_role();
    t_nv_write();
    t_resync();
    summarize();
  end
endmodule
